// file: uds_pkg.sv
// What this block does
// - separate tx and rx lines, full duplex
// - character width selectable, five to nine
// - parity none, even or odd, generated, checked
// - one or two stop bits per frame
// - programmable bit rate, default 9600 baud
// - rts needs receive, cts needs transmit
// - default pins only means no flow control
// - break holds tx low thirteen bit times
// - receive interrupt every eight new characters
// - interrupt on waiting character after idle frame
// - interrupt priority one to seven, higher wins
// - software reads count of buffered characters
// - two instances, zero is the default
`default_nettype none
package uds_pkg;
	localparam int unsigned CLK_HZ    = 20_000_000;             // system clock rate
	localparam int unsigned BAUD_DEF  = 9600;                   // bit rate when none is given
	localparam logic [15:0] DIV_DEF   = 16'(CLK_HZ / BAUD_DEF); // clocks per bit at default rate
	localparam int unsigned BRK_BITS  = 13;                     // break length in bit times
	localparam logic [3:0]  BRK_LAST  = 4'(BRK_BITS - 1);       // last break bit index
	localparam logic [3:0]  IRQ_CHARS = 4'h8;                   // characters per interrupt
	localparam int unsigned DEPTH     = 16;                     // receive buffer depth
	localparam int unsigned AW        = 4;                      // buffer address width
	localparam logic [4:0]  CNT_FULL  = 5'h10;                  // count when buffer full
	localparam logic [4:0]  RTS_LIM   = 5'h0E;                  // rts released at this count
	localparam logic [3:0]  BITS_MIN  = 4'h5;                   // narrowest character
	localparam logic [3:0]  BITS_MAX  = 4'h9;                   // widest character
	localparam logic [1:0]  PAR_NONE  = 2'h0;                   // parity codes
	localparam logic [1:0]  PAR_EVEN  = 2'h1;
	localparam logic [1:0]  PAR_ODD   = 2'h2;
	localparam logic [2:0]  PRIO_MIN  = 3'h1;                   // lowest legal priority
	localparam logic        PORT_DEF  = 1'b0;                   // default instance number

	// transmit states, one-hot
	typedef enum logic [5:0] {
		TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
		TX_PAR = 6'h08, TX_STOP = 6'h10, TX_BRK = 6'h20
	} uds_tx_e;

	// receive states, one-hot
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
	} uds_rx_e;

	// clocks per bit, zero selects the default rate
	function automatic logic [15:0] uds_div(input logic [15:0] d);
		return (d == 16'h0000) ? DIV_DEF : d;
	endfunction

	// clamp character width into five..nine
	function automatic logic [3:0] uds_width(input logic [3:0] b);
		if (b < BITS_MIN)
			return BITS_MIN;
		if (b > BITS_MAX)
			return BITS_MAX;
		return b;
	endfunction

	// keep only the low w bits of a character
	function automatic logic [8:0] uds_mask(input logic [8:0] d, input logic [3:0] w);
		return d & ~(9'h1FF << w);
	endfunction

	// bits in one frame: start, data, parity, stop
	function automatic logic [3:0] uds_frame(input logic [3:0] w, input logic [1:0] p, input logic s2);
		return 4'h1 + w + {3'h0, p != PAR_NONE} + (s2 ? 4'h2 : 4'h1);
	endfunction
endpackage
`default_nettype wire

// file: uds_mem_if.sv
`default_nettype none
// receive buffer access between the port logic and its memory
interface uds_mem_if;
	logic          wr_en;   // write strobe
	logic [3:0]    wr_addr; // write address
	logic [9:0]    wr_data; // parity error flag and character
	logic [3:0]    rd_addr; // read address
	logic [9:0]    rd_data; // registered read data

	modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: uds_rxmem.sv
`default_nettype none
// receive character store, read data registered every clock
module uds_rxmem
	import uds_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	uds_mem_if.mem    mif
);
	typedef struct packed {
		logic [9:0] rd_data; // read register
	} uds_mem_s;

	logic [9:0] ram [DEPTH];  // storage, no reset needed
	uds_mem_s   st_r;          // registered state
	uds_mem_s   st_nxt;        // next state

	// read data follows the read address one clock later
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_data = ram[mif.rd_addr];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// storage write
	always_ff @(posedge clk_sys) begin
		if (mif.wr_en)
			ram[mif.wr_addr] <= mif.wr_data;
	end

	assign mif.rd_data = st_r.rd_data;
endmodule // uds_rxmem
`default_nettype wire

// file: uds_uart.sv
`default_nettype none
// full-duplex asynchronous serial port with receive buffer and interrupt
module uds_uart
	import uds_pkg::*;
#(
	parameter logic PORT_ID = PORT_DEF // instance number, zero or one
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       cfg_rx_en,
	input  wire logic       cfg_tx_en,
	input  wire logic       cfg_rts_en,
	input  wire logic       cfg_cts_en,
	input  wire logic [3:0] cfg_bits,
	input  wire logic [1:0] cfg_parity,
	input  wire logic       cfg_stop2,
	input  wire logic [15:0] cfg_baud_div,
	input  wire logic [2:0] cfg_irq_prio,
	input  wire logic       tx_valid,
	input  wire logic [8:0] tx_data,
	output var  logic       tx_ready,
	input  wire logic       brk_req,
	output var  logic       brk_busy,
	input  wire logic       rd_req,
	output var  logic [8:0] rd_data,
	output var  logic       rd_perr,
	output var  logic       rd_valid,
	output var  logic [4:0] rx_count,
	output var  logic       rx_ferr,
	output var  logic       rx_ovr,
	input  wire logic       err_clr,
	output var  logic       irq_rx,
	output var  logic [2:0] irq_prio,
	output var  logic       port_num,
	output var  logic       tx_line,
	input  wire logic       rx_line,
	output var  logic       rts_n,
	input  wire logic       cts_n
);
	typedef struct packed {
		uds_tx_e     txs;      // transmit state
		logic [15:0] tcnt;     // transmit bit timer
		logic [3:0]  tbit;     // transmit bit index
		logic [8:0]  tsh;      // transmit shifter
		logic        tpar;     // transmit parity bit
		logic        tx_line;  // line driver
		logic        tx_ready; // ready for a character
		logic        brk_busy; // break in progress
		uds_rx_e     rxs;      // receive state
		logic [15:0] rcnt;     // receive sample timer
		logic [3:0]  rbit;     // receive bit index
		logic [8:0]  rsh;      // receive shifter
		logic        rpar;     // received parity bit
		logic [15:0] icnt;     // idle bit timer
		logic [3:0]  ibit;     // idle bit times seen
		logic [3:0]  since;    // characters since last interrupt
		logic [3:0]  wptr;     // buffer write pointer
		logic [3:0]  rptr;     // buffer read pointer
		logic [4:0]  cnt;      // characters held
		logic        rd_valid; // read data valid
		logic        ferr;     // sticky framing error
		logic        ovr;      // sticky overrun
		logic        irq;      // interrupt pulse
		logic [2:0]  prio;     // interrupt priority
		logic        rts_n;    // rts driver
		logic        port;     // instance number
	} uds_state_s;

	localparam uds_state_s ST_RST = '{txs: TX_IDLE, rxs: RX_IDLE, tx_line: 1'b1, rts_n: 1'b1,
		prio: PRIO_MIN, port: PORT_DEF, default: '0};

	uds_state_s  st_r;    // registered state
	uds_state_s  st_nxt;  // next state
	uds_mem_if   mif ();  // buffer access
	logic [15:0] div;     // clocks per bit
	logic [3:0]  wid;     // character width
	logic        par_en;  // parity in use
	logic        odd;     // odd parity chosen
	logic        tdone;   // transmit bit time over
	logic        rdone;   // receive sample point
	logic        rx_frm;  // frame complete this clock
	logic [8:0]  rx_chr;  // right-justified character
	logic        wr;      // character enters buffer
	logic        rd;      // character leaves buffer

	// configuration decode
	always_comb begin
		div    = uds_div(cfg_baud_div);
		wid    = uds_width(cfg_bits);
		par_en = (cfg_parity != PAR_NONE);
		odd    = (cfg_parity == PAR_ODD);
		tdone  = (st_r.tcnt == 16'h0000);
		rdone  = (st_r.rcnt == 16'h0000);
	end

	// next state of the whole port
	always_comb begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		rx_frm = 1'b0;
		rx_chr = 9'(st_r.rsh >> (BITS_MAX - wid));
		// transmit bit timer runs outside idle
		if (st_r.txs != TX_IDLE)
			st_nxt.tcnt = tdone ? div - 16'h0001 : st_r.tcnt - 16'h0001;
		unique case (st_r.txs)
			TX_IDLE: begin
				// a character wins over a break in the same clock
				if (st_r.tx_ready && tx_valid) begin
					st_nxt.txs  = TX_START;
					st_nxt.tsh  = uds_mask(tx_data, wid);
					st_nxt.tpar = (^uds_mask(tx_data, wid)) ^ odd;
					st_nxt.tcnt = div - 16'h0001;
				end else if (brk_req && cfg_tx_en) begin
					st_nxt.txs  = TX_BRK;
					st_nxt.tbit = 4'h0;
					st_nxt.tcnt = div - 16'h0001;
				end
			end
			TX_START: begin
				// start bit over, first data bit next
				if (tdone) begin
					st_nxt.txs  = TX_DATA;
					st_nxt.tbit = 4'h0;
				end
			end
			TX_DATA: begin
				// shift out lsb first
				if (tdone) begin
					st_nxt.tsh  = st_r.tsh >> 1;
					st_nxt.tbit = st_r.tbit + 4'h1;
					if (st_r.tbit == wid - 4'h1) begin
						st_nxt.txs  = par_en ? TX_PAR : TX_STOP;
						st_nxt.tbit = 4'h0;
					end
				end
			end
			TX_PAR: begin
				if (tdone)
					st_nxt.txs = TX_STOP;
			end
			TX_STOP: begin
				// one or two stop bits
				if (tdone) begin
					if (cfg_stop2 && st_r.tbit == 4'h0)
						st_nxt.tbit = 4'h1;
					else
						st_nxt.txs = TX_IDLE;
				end
			end
			TX_BRK: begin
				// line held low for the whole break
				if (tdone) begin
					st_nxt.tbit = st_r.tbit + 4'h1;
					if (st_r.tbit == BRK_LAST)
						st_nxt.txs = TX_IDLE;
				end
			end
		endcase
		// line level for the coming bit
		unique case (st_nxt.txs)
			TX_START, TX_BRK: st_nxt.tx_line = 1'b0;
			TX_DATA:          st_nxt.tx_line = st_nxt.tsh[0];
			TX_PAR:           st_nxt.tx_line = st_nxt.tpar;
			TX_IDLE, TX_STOP: st_nxt.tx_line = 1'b1;
		endcase
		// ready only when idle, enabled and not held off by cts
		st_nxt.tx_ready = (st_nxt.txs == TX_IDLE) && cfg_tx_en && !(cfg_cts_en && cts_n);
		st_nxt.brk_busy = (st_nxt.txs == TX_BRK);

		// receive sample timer runs outside idle
		if (st_r.rxs != RX_IDLE)
			st_nxt.rcnt = rdone ? div - 16'h0001 : st_r.rcnt - 16'h0001;
		unique case (st_r.rxs)
			RX_IDLE: begin
				// a low line level starts a frame, sample mid bit
				if (cfg_rx_en && !rx_line) begin
					st_nxt.rxs  = RX_START;
					st_nxt.rcnt = div >> 1;
				end
			end
			RX_START: begin
				// a start bit gone high again was a glitch
				if (rdone) begin
					st_nxt.rxs  = rx_line ? RX_IDLE : RX_DATA;
					st_nxt.rbit = 4'h0;
				end
			end
			RX_DATA: begin
				// bits arrive lsb first into the top of the shifter
				if (rdone) begin
					st_nxt.rsh  = {rx_line, st_r.rsh[8:1]};
					st_nxt.rbit = st_r.rbit + 4'h1;
					if (st_r.rbit == wid - 4'h1)
						st_nxt.rxs = par_en ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR: begin
				if (rdone) begin
					st_nxt.rpar = rx_line;
					st_nxt.rxs  = RX_STOP;
				end
			end
			RX_STOP: begin
				// first stop bit checked, frame ends mid stop bit
				if (rdone) begin
					st_nxt.rxs = RX_IDLE;
					rx_frm = 1'b1;
					if (!rx_line)
						st_nxt.ferr = 1'b1;
				end
			end
		endcase

		// buffer bookkeeping
		wr = rx_frm && (st_r.cnt != CNT_FULL);
		rd = rd_req && (st_r.cnt != 5'h00);
		if (err_clr) begin
			st_nxt.ferr = 1'b0;
			st_nxt.ovr  = 1'b0;
		end
		// a new error wins over a clear in the same clock
		if (rx_frm && !rx_line)
			st_nxt.ferr = 1'b1;
		if (rx_frm && !wr)
			st_nxt.ovr = 1'b1;
		if (wr)
			st_nxt.wptr = st_r.wptr + 4'h1;
		if (rd)
			st_nxt.rptr = st_r.rptr + 4'h1;
		st_nxt.cnt = st_r.cnt + {4'h0, wr} - {4'h0, rd};
		st_nxt.rd_valid = rd;

		// idle line timer: counts bit times of silence
		if (st_r.rxs == RX_IDLE && rx_line) begin
			st_nxt.icnt = (st_r.icnt == 16'h0000) ? div - 16'h0001 : st_r.icnt - 16'h0001;
			if (st_r.icnt == 16'h0000 && st_r.ibit != 4'hF)
				st_nxt.ibit = st_r.ibit + 4'h1;
		end else begin
			st_nxt.icnt = div - 16'h0001;
			st_nxt.ibit = 4'h0;
		end

		// interrupt on eight new characters or on a silent frame
		if (wr) begin
			st_nxt.since = st_r.since + 4'h1;
			if (st_r.since + 4'h1 == IRQ_CHARS) begin
				st_nxt.irq   = 1'b1;
				st_nxt.since = 4'h0;
			end
		end else if (st_r.since != 4'h0 && st_r.cnt != 5'h00
				&& st_r.ibit == uds_frame(wid, cfg_parity, cfg_stop2)) begin
			st_nxt.irq   = 1'b1;
			st_nxt.since = 4'h0;
		end
		st_nxt.prio = (cfg_irq_prio < PRIO_MIN) ? PRIO_MIN : cfg_irq_prio;

		// rts asserted only with receive and flow control on, and room left
		st_nxt.rts_n = !(cfg_rx_en && cfg_rts_en && st_nxt.cnt < RTS_LIM);
		st_nxt.port  = PORT_ID;
	end

	// single state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	// buffer hookup
	always_comb begin
		mif.wr_en   = wr;
		mif.wr_addr = st_r.wptr;
		mif.wr_data = {par_en && ((^rx_chr ^ st_r.rpar) != odd), rx_chr};
		mif.rd_addr = st_r.rptr;
	end

	uds_rxmem u_mem (
		.clk_sys (clk_sys),
		.rst     (rst),
		.mif     (mif.mem)
	);

	// outputs, all from flip-flops
	always_comb begin
		tx_ready = st_r.tx_ready;
		brk_busy = st_r.brk_busy;
		rd_data  = mif.rd_data[8:0];
		rd_perr  = mif.rd_data[9];
		rd_valid = st_r.rd_valid;
		rx_count = st_r.cnt;
		rx_ferr  = st_r.ferr;
		rx_ovr   = st_r.ovr;
		irq_rx   = st_r.irq;
		irq_prio = st_r.prio;
		port_num = st_r.port;
		tx_line  = st_r.tx_line;
		rts_n    = st_r.rts_n;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// helper: length of the current break in clocks
	logic [19:0] brk_clk;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			brk_clk <= '0;
		else
			brk_clk <= st_r.brk_busy ? brk_clk + 20'h00001 : 20'h00000;
	end

	property p_brk_len;
		$fell(st_r.brk_busy) |-> brk_clk == 20'(BRK_BITS) * {4'h0, $past(div)};
	endproperty
	a_brk_len: assert property (p_brk_len) else $error("break length wrong");

	property p_brk_low;
		st_r.brk_busy |-> !tx_line;
	endproperty
	a_brk_low: assert property (p_brk_low) else $error("tx high during break");

	property p_start_low;
		$rose(st_r.txs == TX_START) |-> !tx_line && $past(tx_valid && tx_ready);
	endproperty
	a_start_low: assert property (p_start_low) else $error("bad start bit");

	property p_cts_hold;
		tx_ready |-> $past(cfg_tx_en && !(cfg_cts_en && cts_n));
	endproperty
	a_cts_hold: assert property (p_cts_hold) else $error("ready despite cts");

	property p_rts;
		!rts_n |-> $past(cfg_rx_en && cfg_rts_en);
	endproperty
	a_rts: assert property (p_rts) else $error("rts without receive");

	property p_eight;
		wr && st_r.since == 4'h7 |=> irq_rx ##1 !irq_rx;
	endproperty
	a_eight: assert property (p_eight) else $error("missed eight-char irq");

	property p_irq_cause;
		irq_rx |-> $past(st_r.since) != 4'h0 && st_r.since <= 4'h1;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq with nothing new");

	property p_prio;
		##1 irq_prio >= PRIO_MIN;
	endproperty
	a_prio: assert property (p_prio) else $error("priority out of range");

	property p_read;
		rd_req && rx_count != 5'h00 |=> rd_valid && rx_count <= $past(rx_count);
	endproperty
	a_read: assert property (p_read) else $error("read not answered");

	property p_div;
		cfg_baud_div == 16'h0000 |-> div == DIV_DEF;
	endproperty
	a_div: assert property (p_div) else $error("default rate lost");

	c_irq: cover property (irq_rx);
	c_brk: cover property ($fell(brk_busy));
	c_perr: cover property (rd_valid && rd_perr);
	c_full: cover property (rx_count == CNT_FULL);
endmodule // uds_uart
`default_nettype wire

// file: uds_remote.sv
`default_nettype none
// remote serial device facing the port across the line pair
module uds_remote (
	input  wire logic tx_line,
	input  wire logic clk_sys,
	output var  logic rx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rx_line = 1'b1; // line idles high, as if pulled up
	// drive one bit time on our line
	task automatic hold_bit(input logic b, input int div);
		rx_line = b;
		repeat (div) @(negedge clk_sys);
	endtask
	// send one frame; bad flips the parity bit on purpose
	task automatic send(input logic [8:0] d, input int w, input logic [1:0] p, input logic s2,
		input logic bad, input int div);
		logic par;
		par = ^(d & ~(9'h1FF << w)) ^ (p == 2'h2) ^ bad;
		hold_bit(1'b0, div);
		for (int i = 0; i < w; i++)
			hold_bit(d[i], div);
		if (p != 2'h0)
			hold_bit(par, div);
		hold_bit(1'b1, div);
		if (s2)
			hold_bit(1'b1, div);
	endtask
	// capture one frame from the port, sampling mid-bit
	task automatic recv(input int w, input logic [1:0] p, input logic s2, input int div,
		output logic [8:0] d, output logic par, output logic ok);
		int n;
		d = 9'h000;
		par = 1'b0;
		n = 0;
		while (tx_line !== 1'b0 && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		repeat (div / 2) @(negedge clk_sys);
		ok = (tx_line === 1'b0);
		for (int i = 0; i < w; i++) begin
			repeat (div) @(negedge clk_sys);
			d[i] = tx_line;
		end
		if (p != 2'h0) begin
			repeat (div) @(negedge clk_sys);
			par = tx_line;
		end
		for (int i = 0; i < (s2 ? 2 : 1); i++) begin
			repeat (div) @(negedge clk_sys);
			ok &= (tx_line === 1'b1);
		end
	endtask
endmodule // uds_remote
`default_nettype wire

// file: uds_uart_tb_top.sv
`default_nettype none
// bench: drives the port at falling edges, judges every scenario
module uds_uart_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import uds_pkg::*;
	localparam int DIV = 8; // short bit time keeps the run brief
	logic clk_sys, rst, cfg_rx_en, cfg_tx_en, cfg_rts_en, cfg_cts_en, cfg_stop2;
	logic [3:0] cfg_bits;
	logic [1:0] cfg_parity;
	logic [15:0] cfg_baud_div;
	logic [2:0] cfg_irq_prio, irq_prio;
	logic tx_valid, tx_ready, brk_req, brk_busy, rd_req, rd_perr, rd_valid, rx_ferr, rx_ovr;
	logic err_clr, irq_rx, port_num, tx_line, rx_line, rts_n, cts_n;
	logic [8:0] tx_data, rd_data;
	logic [4:0] rx_count;
	int failures = 0;
	int num_checks = 0;
	int irq_seen = 0;
	uds_uart dut_u (.clk_sys, .rst, .cfg_rx_en, .cfg_tx_en, .cfg_rts_en, .cfg_cts_en, .cfg_bits,
		.cfg_parity, .cfg_stop2, .cfg_baud_div, .cfg_irq_prio, .tx_valid, .tx_data, .tx_ready,
		.brk_req, .brk_busy, .rd_req, .rd_data, .rd_perr, .rd_valid, .rx_count, .rx_ferr, .rx_ovr,
		.err_clr, .irq_rx, .irq_prio, .port_num, .tx_line, .rx_line, .rts_n, .cts_n);
	uds_remote rem_u (.clk_sys, .tx_line, .rx_line);
	// clock at 20 MHz
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// count receive interrupt pulses, looked at mid-cycle where they are settled
	always @(negedge clk_sys) begin
		if (irq_rx === 1'b1)
			irq_seen++;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// offer one character and hold it until taken
	task automatic tx_char(input logic [8:0] d);
		for (int n = 0; n < 30000 && tx_ready !== 1'b1; n++)
			@(negedge clk_sys);
		tx_valid = 1'b1;
		tx_data = d;
		@(negedge clk_sys);
		tx_valid = 1'b0;
	endtask
	// pop one character and compare it
	task automatic rd_char(input logic [8:0] d, input logic pe);
		rd_req = 1'b1;
		@(negedge clk_sys);
		rd_req = 1'b0;
		chk("rd_valid", rd_valid, 1'b1);
		chk("rd_data", rd_data, d);
		chk("rd_perr", rd_perr, pe);
		// let an edge pass so a following read raises its strobe afresh
		@(negedge clk_sys);
	endtask
	// measure how long the port holds its line low
	task automatic low_len(output int n);
		n = 0;
		for (int k = 0; k < 30000 && tx_line !== 1'b0; k++)
			@(negedge clk_sys);
		while (tx_line === 1'b0 && n < 30000) begin
			n++;
			@(negedge clk_sys);
		end
	endtask
	// every width, parity and stop setting, both directions at once
	task automatic t_frames;
		int tw[5] = '{5, 6, 7, 8, 9};
		logic [1:0] tp[5] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1};
		logic ts[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		logic [8:0] got, m;
		logic gp, ok;
		for (int i = 0; i < 5; i++) begin
			cfg_bits = 4'(tw[i]);
			cfg_parity = tp[i];
			cfg_stop2 = ts[i];
			m = 9'h1A5 & ~(9'h1FF << tw[i]);
			fork
				tx_char(9'h1A5);
				rem_u.recv(tw[i], tp[i], ts[i], DIV, got, gp, ok);
				rem_u.send(9'h05A, tw[i], tp[i], ts[i], 1'b0, DIV);
			join
			chk("tx_data", got, m);
			chk("tx_frame", ok, 1'b1);
			if (tp[i] != 2'h0)
				chk("tx_par", gp, ^m ^ (tp[i] == 2'h2));
			repeat (2) @(negedge clk_sys);
			chk("rx_count", rx_count, 5'h01);
			rd_char(9'h05A & ~(9'h1FF << tw[i]), 1'b0);
		end
		// port must frame the same way as the remote: 8 bits, even parity, one stop
		cfg_bits = 4'h8;
		cfg_stop2 = 1'b0;
		rem_u.send(9'h033, 8, 2'h1, 1'b0, 1'b1, DIV);
		repeat (2) @(negedge clk_sys);
		rd_char(9'h033, 1'b1);
	endtask
	// break holds the line low for thirteen bit times
	task automatic t_brk;
		int n;
		brk_req = 1'b1;
		@(negedge clk_sys);
		brk_req = 1'b0;
		chk("brk_busy", brk_busy, 1'b1);
		low_len(n);
		chk("brk_len", 16'(n), 16'(13 * DIV));
		chk("brk_done", brk_busy, 1'b0);
	endtask
	// one character and an idle frame, then an eight-character burst
	task automatic t_irq;
		cfg_bits = 4'h8;
		cfg_parity = 2'h0;
		cfg_stop2 = 1'b0;
		cfg_irq_prio = 3'h5;
		irq_seen = 0;
		// six characters are still counted from the frame scenario, this is the seventh
		rem_u.send(9'h0C3, 8, 2'h0, 1'b0, 1'b0, DIV);
		repeat (40) @(negedge clk_sys);
		chk("irq_early", 16'(irq_seen), 16'h0000);
		repeat (80) @(negedge clk_sys);
		chk("irq_idle", 16'(irq_seen), 16'h0001);
		chk("irq_prio", irq_prio, 3'h5);
		rd_char(9'h0C3, 1'b0);
		// the idle interrupt restarted the count, so only the eighth fires
		for (int i = 0; i < 8; i++) begin
			if (i == 7)
				chk("irq_seven", 16'(irq_seen), 16'h0001);
			rem_u.send(9'(8'h10 + i), 8, 2'h0, 1'b0, 1'b0, DIV);
		end
		repeat (3) @(negedge clk_sys);
		chk("irq_burst", 16'(irq_seen), 16'h0002);
		chk("rx_count8", rx_count, 5'h08);
		for (int i = 0; i < 8; i++)
			rd_char(9'(8'h10 + i), 1'b0);
	endtask
	// framing error, overrun on a full buffer, rts release and error clear
	task automatic t_errs;
		cfg_rts_en = 1'b1;
		// ten low bit times: stop bit sampled low, trailing low is a dropped glitch
		rem_u.hold_bit(1'b0, 10 * DIV);
		rem_u.hold_bit(1'b1, DIV);
		chk("rx_ferr", rx_ferr, 1'b1);
		rd_char(9'h000, 1'b0);
		for (int i = 0; i < 17; i++) begin
			if (i == 16) begin
				chk("rx_full", rx_count, 5'h10);
				chk("rx_ovr0", rx_ovr, 1'b0);
				chk("rts_full", rts_n, 1'b1);
			end
			rem_u.send(9'(8'h40 + i), 8, 2'h0, 1'b0, 1'b0, DIV);
		end
		repeat (2) @(negedge clk_sys);
		chk("rx_ovr", rx_ovr, 1'b1);
		chk("rx_keep", rx_count, 5'h10);
		err_clr = 1'b1;
		@(negedge clk_sys);
		err_clr = 1'b0;
		chk("err_clr", {rx_ferr, rx_ovr}, 2'b00);
		for (int i = 0; i < 16; i++)
			rd_char(9'(8'h40 + i), 1'b0);
		chk("rts_room", rts_n, 1'b0);
		cfg_rts_en = 1'b0;
	endtask
	// flow control follows enables and paths
	task automatic t_flow;
		repeat (2) @(negedge clk_sys);
		chk("rts_off", rts_n, 1'b1);
		cfg_rts_en = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk("rts_on", rts_n, 1'b0);
		cfg_rx_en = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("rts_norx", rts_n, 1'b1);
		cfg_rx_en = 1'b1;
		cfg_rts_en = 1'b0;
		cfg_cts_en = 1'b1;
		cts_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk("cts_hold", tx_ready, 1'b0);
		cts_n = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("cts_go", tx_ready, 1'b1);
		cfg_cts_en = 1'b0;
	endtask
	// zero divisor gives the default bit rate
	task automatic t_baud_def;
		int n;
		cfg_baud_div = 16'h0000;
		tx_char(9'h001);
		low_len(n);
		chk("bit_def", 16'(n), 16'(20_000_000 / 9600));
	endtask
	// watchdog cuts a hang short
	initial begin
		repeat (90000) @(posedge clk_sys);
		failures++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{cfg_rts_en, cfg_cts_en, cfg_stop2, tx_valid, brk_req, rd_req, err_clr, cts_n} = 8'h00;
		{cfg_rx_en, cfg_tx_en} = 2'h3;
		cfg_bits = 4'h8;
		cfg_parity = 2'h0;
		cfg_baud_div = 16'(DIV);
		cfg_irq_prio = 3'h3;
		tx_data = 9'h000;
		rst = 1'b1;
		repeat (16) @(negedge clk_sys);
		chk("rst_tx", tx_line, 1'b1);
		chk("rst_rts", rts_n, 1'b1);
		chk("rst_prio", irq_prio, 3'h1);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("port_num", port_num, 1'b0);
		t_flow();
		t_frames();
		t_brk();
		t_irq();
		t_errs();
		t_baud_def();
		tally_and_finish();
	end
endmodule // uds_uart_tb_top
`default_nettype wire
